/* rtl/ehi_pkg.sv */
package ehi_pkg;

	localparam int ADDR_W = 8;
	localparam int DATA_W = 32;
	localparam int NUM_BANKS = 2;
	localparam int SEC_BANK = 0;
	localparam int NUM_EP = 4;
	localparam int EP_ID_W = 2;
	localparam int CNT_W = 3;
	localparam int TYPES_PER_BANK = 3;
	localparam int NUM_TYPES = 7;
	localparam int TYPE_NONMGMT = 6;
	localparam int AXI_ID_W = 8;
	localparam int NODE_W = 8;
	localparam int LEN_W = 8;
	localparam int SIZE_W = 3;

	// Slot 0 is this endpoint; a set bit marks a master-side endpoint.
	localparam logic [NUM_EP-1:0] EP_MASTER_SIDE = 4'h5;

	// Address decode.
	localparam int GLOBAL_BIT = 7;
	localparam int BANK_BIT = 6;
	localparam logic [5:0] OFF_STATUS = 6'h00;
	localparam logic [5:0] OFF_CTRL = 6'h04;
	localparam logic [5:0] OFF_ADDR_LO = 6'h08;
	localparam logic [5:0] OFF_ADDR_HI = 6'h0C;
	localparam logic [5:0] OFF_ATTR0 = 6'h10;
	localparam logic [5:0] OFF_ATTR1 = 6'h14;
	localparam logic [5:0] OFF_INT_STAT = 6'h18;
	localparam logic [5:0] OFF_INT_MASK = 6'h1C;
	localparam logic [5:0] OFF_TO_CTRL = 6'h20;
	localparam logic [ADDR_W-1:0] OFF_NM_STAT = 8'h80;
	localparam logic [ADDR_W-1:0] OFF_NM_MASK = 8'h84;
	localparam logic [ADDR_W-1:0] OFF_NM_CTRL = 8'h88;
	localparam logic [ADDR_W-1:0] OFF_L2_MASK = 8'h8C;
	localparam logic [1:0] L2_INFO_SEL = 2'h3;
	localparam int L2_IDX_LO = 2;
	localparam int L2_IDX_W = 3;

	// Field positions.
	localparam int ST_V = 0;
	localparam int ST_UE = 1;
	localparam int ST_OF = 2;
	localparam int ST_TYPE_LO = 4;
	localparam int CTL_ED = 0;
	localparam int CTL_UI = 1;
	localparam int TO_EN = 0;
	localparam int INT_BUS = 0;
	localparam int INT_TO = 1;
	localparam int INT_ACC = 2;
	localparam int NM_SPLIT = 0;
	localparam int NM_ACP = 1;
	localparam int NM_EARLY = 2;
	localparam int NMC_ACP_MODE = 0;
	localparam int A1_SIZE_LO = 8;
	localparam int L2_ID_LO = 8;
	localparam int L2_FV = 15;

	// Reset values.
	localparam logic ED_RST = 1'b1;
	localparam logic TO_EN_RST = 1'b1;
	localparam logic ACP_MODE_RST = 1'b0;

	// Error type codes held in the status register.
	localparam logic [1:0] ERR_NONE = 2'h0;
	localparam logic [1:0] ERR_BUS = 2'h1;
	localparam logic [1:0] ERR_TIMEOUT = 2'h2;
	localparam logic [1:0] ERR_ACCESS = 2'h3;

	// Request subset checks: 16 bytes is a 128-bit transfer.
	localparam logic [1:0] BURST_WRAP = 2'h2;
	localparam logic [SIZE_W-1:0] ACP_MAX_SIZE = 3'h4;

	typedef enum logic [1:0] {LOG_IDLE, LOG_MARK, LOG_MASK} ehi_log_t;

	function automatic logic [CNT_W-1:0] ehi_count(input logic [NUM_EP-1:0] v);
		logic [CNT_W-1:0] c;
		c = '0;
		for (int i = 0; i < NUM_EP; i++) begin
			c = c + CNT_W'(v[i]);
		end
		return c;
	endfunction : ehi_count

	// Returns {found, id}: master side first, then lowest slot.
	function automatic logic [EP_ID_W:0] ehi_pick(input logic [NUM_EP-1:0] v);
		logic [EP_ID_W:0] r;
		r = '0;
		for (int i = NUM_EP - 1; i >= 0; i--) begin
			if (v[i] && !EP_MASTER_SIDE[i]) begin
				r = {1'b1, EP_ID_W'(i)};
			end
		end
		for (int i = NUM_EP - 1; i >= 0; i--) begin
			if (v[i] && EP_MASTER_SIDE[i]) begin
				r = {1'b1, EP_ID_W'(i)};
			end
		end
		return r;
	endfunction : ehi_pick

endpackage : ehi_pkg

/* rtl/ehi_error_log_irq.sv */
`timescale 1ns/1ps

module ehi_error_log_irq (
	input wire logic i_clk,
	input wire logic i_rst_n,
	input wire logic [ehi_pkg::ADDR_W-1:0] i_addr,
	input wire logic [ehi_pkg::DATA_W-1:0] i_wdata,
	input wire logic i_wr,
	input wire logic i_rd,
	output logic [ehi_pkg::DATA_W-1:0] o_rdata,
	input wire logic i_rd_err,
	input wire logic [2*ehi_pkg::DATA_W-1:0] i_rd_txn_addr,
	input wire logic [ehi_pkg::AXI_ID_W-1:0] i_rd_txn_id,
	input wire logic [ehi_pkg::NODE_W-1:0] i_rd_txn_node,
	input wire logic [ehi_pkg::LEN_W-1:0] i_rd_txn_len,
	input wire logic [ehi_pkg::SIZE_W-1:0] i_rd_txn_size,
	input wire logic i_rd_txn_secure,
	input wire logic i_wr_err,
	input wire logic [2*ehi_pkg::DATA_W-1:0] i_wr_txn_addr,
	input wire logic [ehi_pkg::AXI_ID_W-1:0] i_wr_txn_id,
	input wire logic [ehi_pkg::NODE_W-1:0] i_wr_txn_node,
	input wire logic [ehi_pkg::LEN_W-1:0] i_wr_txn_len,
	input wire logic [ehi_pkg::SIZE_W-1:0] i_wr_txn_size,
	input wire logic i_wr_txn_secure,
	input wire logic i_timeout_err,
	input wire logic i_timeout_is_wr,
	input wire logic i_access_err,
	input wire logic i_access_is_wr,
	input wire logic i_split_nonmod,
	input wire logic i_early_wr_err,
	input wire logic i_subset_req,
	input wire logic [1:0] i_subset_burst,
	input wire logic [ehi_pkg::SIZE_W-1:0] i_subset_size,
	input wire logic [(ehi_pkg::NUM_EP-1)*ehi_pkg::NUM_TYPES-1:0] i_ep_irq,
	output logic [ehi_pkg::NUM_TYPES-1:0] o_own_irq,
	output logic [ehi_pkg::NUM_TYPES-1:0] o_irq,
	output logic [ehi_pkg::NUM_BANKS-1:0] o_ras_err
);

	localparam int NB = ehi_pkg::NUM_BANKS;
	localparam int NT = ehi_pkg::NUM_TYPES;
	localparam int DW = ehi_pkg::DATA_W;

	wire [NB-1:0][DW-1:0] bank_rdata;
	wire [NB-1:0][ehi_pkg::TYPES_PER_BANK-1:0] bank_irq;
	wire [NB-1:0] bank_ras;
	wire [NT-1:0][DW-1:0] l2_info;
	wire [NT-1:0] l2_out;
	logic [DW-1:0] next_rdata;
	logic [2:0] nm_stat;
	logic [2:0] nm_mask;
	logic acp_mode;
	logic [NT-1:0] l2_mask;
	logic [2:0] nm_set;
	logic glb_wr;

	assign glb_wr = i_wr && i_addr[ehi_pkg::GLOBAL_BIT];

	// One logging bank per security state, each with its own registers and outputs.
	for (genvar b = 0; b < NB; b++) begin : g_bank
		logic sel_wr;
		logic sel_rd;
		logic [5:0] off;
		logic chan_ok_rd;
		logic chan_ok_wr;
		logic e_rd;
		logic e_wr;
		logic e_to;
		logic e_acc;
		logic any_ev;
		logic multi_ev;
		logic capture;
		logic take_wr;
		logic [1:0] ev_type;
		logic [2:0] int_set;
		logic v;
		logic ue;
		logic of;
		logic ui;
		logic ed;
		logic to_en;
		logic [1:0] held_type;
		logic [2*DW-1:0] held_addr;
		logic [DW-1:0] attr0;
		logic [DW-1:0] attr1;
		logic [2:0] int_stat;
		logic [2:0] int_mask;
		ehi_pkg::ehi_log_t stage;
		logic [DW-1:0] rd_mux;

		assign off = i_addr[5:0];
		assign sel_wr = i_wr && !i_addr[ehi_pkg::GLOBAL_BIT]
			&& (i_addr[ehi_pkg::BANK_BIT] == 1'(b));
		assign sel_rd = !i_addr[ehi_pkg::GLOBAL_BIT] && (i_addr[ehi_pkg::BANK_BIT] == 1'(b));
		assign chan_ok_rd = (i_rd_txn_secure == (b == ehi_pkg::SEC_BANK));
		assign chan_ok_wr = (i_wr_txn_secure == (b == ehi_pkg::SEC_BANK));

		// Detection is gated by the enables, not by soft reset state.
		assign e_rd = i_rd_err && ed && chan_ok_rd;
		assign e_wr = i_wr_err && ed && chan_ok_wr;
		assign e_to = i_timeout_err && ed && to_en
			&& (i_timeout_is_wr ? chan_ok_wr : chan_ok_rd);
		assign e_acc = i_access_err && ed && (i_access_is_wr ? chan_ok_wr : chan_ok_rd);
		assign any_ev = e_rd || e_wr || e_to || e_acc;
		assign multi_ev = (32'(e_rd) + 32'(e_wr) + 32'(e_to) + 32'(e_acc)) > 32'd1;
		assign capture = any_ev && !v && (stage == ehi_pkg::LOG_IDLE);

		always_comb begin
			if (e_to) begin
				take_wr = i_timeout_is_wr;
				ev_type = ehi_pkg::ERR_TIMEOUT;
			end else if (e_wr) begin
				take_wr = 1'b1;
				ev_type = ehi_pkg::ERR_BUS;
			end else if (e_rd) begin
				take_wr = 1'b0;
				ev_type = ehi_pkg::ERR_BUS;
			end else begin
				take_wr = i_access_is_wr;
				ev_type = ehi_pkg::ERR_ACCESS;
			end
		end

		// Details land first; valid and uncorrected follow, then the signal mask.
		always_ff @(posedge i_clk or negedge i_rst_n) begin
			if (!i_rst_n) begin
				stage <= ehi_pkg::LOG_IDLE;
			end else begin
				case (stage)
					ehi_pkg::LOG_IDLE: begin
						if (capture) begin
							stage <= ehi_pkg::LOG_MARK;
						end
					end
					ehi_pkg::LOG_MARK: begin
						stage <= ehi_pkg::LOG_MASK;
					end
					ehi_pkg::LOG_MASK: begin
						stage <= ehi_pkg::LOG_IDLE;
					end
					default: begin
						stage <= ehi_pkg::LOG_IDLE;
					end
				endcase
			end
		end

		always_ff @(posedge i_clk or negedge i_rst_n) begin
			if (!i_rst_n) begin
				held_type <= ehi_pkg::ERR_NONE;
				held_addr <= '0;
				attr0 <= '0;
				attr1 <= '0;
			end else if (capture) begin
				held_type <= ev_type;
				held_addr <= take_wr ? i_wr_txn_addr : i_rd_txn_addr;
				attr0 <= take_wr ? {16'h0000, i_wr_txn_node, i_wr_txn_id}
					: {16'h0000, i_rd_txn_node, i_rd_txn_id};
				attr1 <= take_wr ? {21'h000000, i_wr_txn_size, i_wr_txn_len}
					: {21'h000000, i_rd_txn_size, i_rd_txn_len};
			end
		end

		// Hardware set wins over a same-cycle software clear.
		always_ff @(posedge i_clk or negedge i_rst_n) begin
			if (!i_rst_n) begin
				v <= 1'b0;
				ue <= 1'b0;
			end else if (stage == ehi_pkg::LOG_MARK) begin
				v <= 1'b1;
				ue <= 1'b1;
			end else if (sel_wr && off == ehi_pkg::OFF_STATUS && i_wdata[ehi_pkg::ST_V]) begin
				v <= 1'b0;
				ue <= 1'b0;
			end
		end

		always_ff @(posedge i_clk or negedge i_rst_n) begin
			if (!i_rst_n) begin
				of <= 1'b0;
			end else if ((any_ev && (v || stage != ehi_pkg::LOG_IDLE)) || (capture && multi_ev)) begin
				of <= 1'b1;
			end else if (sel_wr && off == ehi_pkg::OFF_STATUS && i_wdata[ehi_pkg::ST_OF]) begin
				of <= 1'b0;
			end
		end

		always_ff @(posedge i_clk or negedge i_rst_n) begin
			if (!i_rst_n) begin
				ui <= 1'b0;
				ed <= ehi_pkg::ED_RST;
			end else begin
				if (stage == ehi_pkg::LOG_MASK) begin
					ui <= 1'b1;
				end else if (sel_wr && off == ehi_pkg::OFF_CTRL) begin
					ui <= i_wdata[ehi_pkg::CTL_UI];
				end
				if (sel_wr && off == ehi_pkg::OFF_CTRL) begin
					ed <= i_wdata[ehi_pkg::CTL_ED];
				end
			end
		end

		always_ff @(posedge i_clk or negedge i_rst_n) begin
			if (!i_rst_n) begin
				to_en <= ehi_pkg::TO_EN_RST;
			end else if (sel_wr && off == ehi_pkg::OFF_TO_CTRL) begin
				to_en <= i_wdata[ehi_pkg::TO_EN];
			end
		end

		assign int_set[ehi_pkg::INT_BUS] = e_rd || e_wr;
		assign int_set[ehi_pkg::INT_TO] = e_to;
		assign int_set[ehi_pkg::INT_ACC] = e_acc;

		// Interrupt status is cleared apart from the held flag.
		always_ff @(posedge i_clk or negedge i_rst_n) begin
			if (!i_rst_n) begin
				int_stat <= '0;
				int_mask <= '0;
			end else begin
				if (sel_wr && off == ehi_pkg::OFF_INT_STAT) begin
					int_stat <= (int_stat & ~i_wdata[2:0]) | int_set;
				end else begin
					int_stat <= int_stat | int_set;
				end
				if (sel_wr && off == ehi_pkg::OFF_INT_MASK) begin
					int_mask <= i_wdata[2:0];
				end
			end
		end

		assign bank_irq[b] = int_stat & ~int_mask;
		assign bank_ras[b] = v && ue && !ui;

		always_comb begin
			rd_mux = '0;
			case (off)
				ehi_pkg::OFF_STATUS: begin
					rd_mux[ehi_pkg::ST_V] = v;
					rd_mux[ehi_pkg::ST_UE] = ue;
					rd_mux[ehi_pkg::ST_OF] = of;
					rd_mux[ehi_pkg::ST_TYPE_LO +: 2] = held_type;
				end
				ehi_pkg::OFF_CTRL: begin
					rd_mux[ehi_pkg::CTL_ED] = ed;
					rd_mux[ehi_pkg::CTL_UI] = ui;
				end
				ehi_pkg::OFF_ADDR_LO: rd_mux = held_addr[DW-1:0];
				ehi_pkg::OFF_ADDR_HI: rd_mux = held_addr[2*DW-1:DW];
				ehi_pkg::OFF_ATTR0: rd_mux = attr0;
				ehi_pkg::OFF_ATTR1: rd_mux = attr1;
				ehi_pkg::OFF_INT_STAT: rd_mux[2:0] = int_stat;
				ehi_pkg::OFF_INT_MASK: rd_mux[2:0] = int_mask;
				ehi_pkg::OFF_TO_CTRL: rd_mux[ehi_pkg::TO_EN] = to_en;
				default: rd_mux = '0;
			endcase
		end

		assign bank_rdata[b] = sel_rd ? rd_mux : '0;
	end

	// Non-management events, shared by both banks.
	assign nm_set[ehi_pkg::NM_SPLIT] = i_split_nonmod;
	assign nm_set[ehi_pkg::NM_ACP] = acp_mode && i_subset_req
		&& (i_subset_burst == ehi_pkg::BURST_WRAP
		|| i_subset_size > ehi_pkg::ACP_MAX_SIZE);
	assign nm_set[ehi_pkg::NM_EARLY] = i_early_wr_err;

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			nm_stat <= '0;
		end else if (glb_wr && i_addr == ehi_pkg::OFF_NM_STAT) begin
			nm_stat <= (nm_stat & ~i_wdata[2:0]) | nm_set;
		end else begin
			nm_stat <= nm_stat | nm_set;
		end
	end

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			nm_mask <= '0;
			acp_mode <= ehi_pkg::ACP_MODE_RST;
			l2_mask <= '0;
		end else if (glb_wr) begin
			if (i_addr == ehi_pkg::OFF_NM_MASK) begin
				nm_mask <= i_wdata[2:0];
			end
			if (i_addr == ehi_pkg::OFF_NM_CTRL) begin
				acp_mode <= i_wdata[ehi_pkg::NMC_ACP_MODE];
			end
			if (i_addr == ehi_pkg::OFF_L2_MASK) begin
				l2_mask <= i_wdata[NT-1:0];
			end
		end
	end

	// Own internal interrupts are registered before they join the domain unit.
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_own_irq <= '0;
			o_ras_err <= '0;
		end else begin
			o_own_irq <= {|(nm_stat & ~nm_mask), bank_irq};
			o_ras_err <= bank_ras;
		end
	end

	// Domain unit: one collator per interrupt type.
	for (genvar t = 0; t < NT; t++) begin : g_l2
		logic [ehi_pkg::NUM_EP-1:0] asserting;
		logic [ehi_pkg::CNT_W-1:0] next_cnt;
		logic [ehi_pkg::CNT_W-1:0] cnt;
		logic [ehi_pkg::EP_ID_W:0] pick;
		logic first_v;
		logic [ehi_pkg::EP_ID_W-1:0] first_id;

		assign asserting[0] = o_own_irq[t];
		for (genvar e = 1; e < ehi_pkg::NUM_EP; e++) begin : g_ep
			assign asserting[e] = i_ep_irq[(e-1)*NT+t];
		end

		assign next_cnt = ehi_pkg::ehi_count(asserting);
		assign pick = ehi_pkg::ehi_pick(asserting);

		always_ff @(posedge i_clk or negedge i_rst_n) begin
			if (!i_rst_n) begin
				cnt <= '0;
				first_v <= 1'b0;
				first_id <= '0;
			end else begin
				cnt <= next_cnt;
				// A shown interface keeps the record until its own line drops.
				if (!first_v || !asserting[first_id]) begin
					first_v <= pick[ehi_pkg::EP_ID_W];
					first_id <= pick[ehi_pkg::EP_ID_W-1:0];
				end
			end
		end

		assign l2_out[t] = !l2_mask[t] && next_cnt != '0;
		assign l2_info[t] = {16'h0000, first_v, 5'h00, first_id, 5'h00, cnt};
	end

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_irq <= '0;
		end else begin
			o_irq <= l2_out;
		end
	end

	always_comb begin
		next_rdata = '0;
		if (i_rd) begin
			if (!i_addr[ehi_pkg::GLOBAL_BIT]) begin
				next_rdata = bank_rdata[0] | bank_rdata[1];
			end else if (i_addr[7:6] == ehi_pkg::L2_INFO_SEL) begin
				if (32'(i_addr[ehi_pkg::L2_IDX_LO +: ehi_pkg::L2_IDX_W]) < NT) begin
					next_rdata = l2_info[i_addr[ehi_pkg::L2_IDX_LO +: ehi_pkg::L2_IDX_W]];
				end
			end else begin
				case (i_addr)
					ehi_pkg::OFF_NM_STAT: next_rdata[2:0] = nm_stat;
					ehi_pkg::OFF_NM_MASK: next_rdata[2:0] = nm_mask;
					ehi_pkg::OFF_NM_CTRL: next_rdata[ehi_pkg::NMC_ACP_MODE] = acp_mode;
					ehi_pkg::OFF_L2_MASK: next_rdata[NT-1:0] = l2_mask;
					default: next_rdata = '0;
				endcase
			end
		end
	end

	// Read data stands in the cycle after each cycle with i_rd high and is zero otherwise.
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_rdata <= '0;
		end else begin
			o_rdata <= next_rdata;
		end
	end

endmodule : ehi_error_log_irq

/* testbench/ehi_monitor.sv */
`timescale 1ns/1ps
module ehi_monitor (
	input wire logic i_clk,
	input wire logic i_rst_n,
	input wire logic i_wr,
	input wire logic i_rd,
	input wire logic [ehi_pkg::DATA_W-1:0] o_rdata,
	input wire logic i_rd_err,
	input wire logic i_rd_txn_secure,
	input wire logic i_wr_err,
	input wire logic i_wr_txn_secure,
	input wire logic i_timeout_err,
	input wire logic i_timeout_is_wr,
	input wire logic i_split_nonmod,
	input wire logic i_early_wr_err,
	input wire logic i_subset_req,
	input wire logic [(ehi_pkg::NUM_EP-1)*ehi_pkg::NUM_TYPES-1:0] i_ep_irq,
	input wire logic [ehi_pkg::NUM_TYPES-1:0] o_own_irq,
	input wire logic [ehi_pkg::NUM_TYPES-1:0] o_irq,
	input wire logic [ehi_pkg::NUM_BANKS-1:0] o_ras_err
);
	default clocking @(posedge i_clk);
	endclocking
	default disable iff (!i_rst_n);
	logic bus_sec;
	logic to_sec;
	logic [ehi_pkg::NUM_TYPES-1:0] line;
	assign bus_sec = (i_rd_err & i_rd_txn_secure) | (i_wr_err & i_wr_txn_secure);
	assign to_sec = i_timeout_err & (i_timeout_is_wr ? i_wr_txn_secure : i_rd_txn_secure);
	// Unmasking is a register write, so a write two cycles back also explains a rising line.
	always_comb begin
		for (int t = 0; t < ehi_pkg::NUM_TYPES; t++) begin
			line[t] = o_own_irq[t] | i_ep_irq[t] | i_ep_irq[7+t] | i_ep_irq[14+t];
		end
	end
	sequence s_pulse0;
		o_ras_err[0] ##1 (!o_ras_err[0]) [*2];
	endsequence
	sequence s_pulse1;
		o_ras_err[1] ##1 (!o_ras_err[1]) [*2];
	endsequence
	property p_ras0;
		$rose(o_ras_err[0]) |-> s_pulse0;
	endproperty
	property p_ras1;
		$rose(o_ras_err[1]) |-> s_pulse1;
	endproperty
	property p_rdata;
		o_rdata != '0 |-> $past(i_rd);
	endproperty
	property p_irq;
		(o_irq & ~$past(line)) == '0;
	endproperty
	property p_bus;
		$rose(o_own_irq[0]) |-> $past(bus_sec, 2) || $past(i_wr, 2);
	endproperty
	property p_tmo;
		$rose(o_own_irq[1]) |-> $past(to_sec, 2) || $past(i_wr, 2);
	endproperty
	property p_nm;
		$rose(o_own_irq[6]) |-> $past(i_subset_req | i_split_nonmod | i_early_wr_err | i_wr, 2);
	endproperty
	property p_hold;
		($past(o_own_irq) & ~o_own_irq) != '0 |-> $past(i_wr, 2);
	endproperty
	a_ras0: assert property (p_ras0) else $error("ras0 pulse wrong");
	a_ras1: assert property (p_ras1) else $error("ras1 pulse wrong");
	a_rdata: assert property (p_rdata) else $error("rdata without read");
	a_irq: assert property (p_irq) else $error("irq without line");
	a_bus: assert property (p_bus) else $error("bus irq without cause");
	a_tmo: assert property (p_tmo) else $error("timeout irq without cause");
	a_nm: assert property (p_nm) else $error("nm irq without cause");
	a_hold: assert property (p_hold) else $error("irq dropped without write");
endmodule : ehi_monitor
bind ehi_error_log_irq ehi_monitor ehi_monitor_inst (.*);

/* testbench/ehi_ep_model.sv */
`timescale 1ns/1ps
// Other endpoints: each line is a sticky status bit that only its own clear drops.
module ehi_ep_model (
	input wire logic i_clk,
	input wire logic i_rst_n,
	input wire logic [20:0] i_raise,
	input wire logic [20:0] i_clear,
	output logic [20:0] o_ep_irq
);
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_ep_irq <= '0;
		end else begin
			o_ep_irq <= (o_ep_irq & ~i_clear) | i_raise;
		end
	end
endmodule : ehi_ep_model

/* testbench/ehi_error_log_irq_test.sv */
`timescale 1ns/1ps
module ehi_error_log_irq_test;
	logic i_clk, i_rst_n, i_wr, i_rd;
	logic [7:0] i_addr;
	logic [31:0] i_wdata, o_rdata;
	logic i_rd_err, i_wr_err, i_timeout_err, i_access_err, i_timeout_is_wr;
	logic i_rd_txn_secure, i_wr_txn_secure, i_split_nonmod, i_early_wr_err, i_subset_req;
	logic [1:0] i_subset_burst, o_ras_err;
	logic [2:0] i_subset_size;
	logic [6:0] o_own_irq, o_irq;
	logic [20:0] raise, clear, ep_irq;
	logic [63:0] rd_a = 64'h0000_005A_0621_ABCD;
	logic [63:0] wr_a = 64'h0000_00A5_0312_3456;
	logic [7:0] ras0_n = 8'h00;
	logic [7:0] ras1_n = 8'h00;
	int errors = 0;
	int n_compared = 0;
	ehi_error_log_irq ehi_error_log_irq_inst (
		.*,
		.i_rd_txn_addr(rd_a),
		.i_rd_txn_id(rd_a[7:0]),
		.i_rd_txn_node(rd_a[15:8]),
		.i_rd_txn_len(rd_a[23:16]),
		.i_rd_txn_size(rd_a[26:24]),
		.i_wr_txn_addr(wr_a),
		.i_wr_txn_id(wr_a[7:0]),
		.i_wr_txn_node(wr_a[15:8]),
		.i_wr_txn_len(wr_a[23:16]),
		.i_wr_txn_size(wr_a[26:24]),
		.i_access_is_wr(i_timeout_is_wr),
		.i_ep_irq(ep_irq)
	);
	ehi_ep_model ehi_ep_model_inst (
		.i_clk(i_clk),
		.i_rst_n(i_rst_n),
		.i_raise(raise),
		.i_clear(clear),
		.o_ep_irq(ep_irq)
	);
	// Each logged error must pulse its bank's signalling line exactly once.
	always @(posedge i_clk) begin
		if (i_rst_n) begin
			ras0_n <= ras0_n + 8'(o_ras_err[0]);
			ras1_n <= ras1_n + 8'(o_ras_err[1]);
		end
	end
	task automatic end_of_test();
		$display("compared %0d errors %0d", n_compared, errors);
		if (errors == 0 && n_compared > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask : end_of_test
	task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
		n_compared++;
		if (got !== exp) begin
			errors++;
			$display("Error %s expected %h seen %h", name, exp, got);
		end
	endtask : chk
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge i_clk);
		i_wr <= 1'b1;
		i_addr <= a;
		i_wdata <= d;
		@(posedge i_clk);
		i_wr <= 1'b0;
	endtask : wr
	// The mask hides fields that keep stale contents once the valid bit is gone.
	task automatic rdc(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m = '1);
		@(posedge i_clk);
		i_rd <= 1'b1;
		i_addr <= a;
		@(posedge i_clk);
		i_rd <= 1'b0;
		#1;
		chk($sformatf("reg %h", a), e & m, o_rdata & m);
	endtask : rdc
	task automatic evt(input logic [4:0] e);
		@(posedge i_clk);
		{i_rd_err, i_wr_err, i_timeout_err, i_access_err, i_timeout_is_wr} <= e;
		@(posedge i_clk);
		{i_rd_err, i_wr_err, i_timeout_err, i_access_err} <= 4'h0;
		repeat (4) @(posedge i_clk);
	endtask : evt
	task automatic clr(input logic [7:0] b);
		wr(b, 32'h7);
		wr(b + 8'h18, 32'h7);
		wr(b + 8'h04, 32'h1);
	endtask : clr
	task automatic nm(input logic [2:0] p, input logic [4:0] bs, input logic [2:0] e);
		@(posedge i_clk);
		{i_subset_req, i_split_nonmod, i_early_wr_err} <= p;
		{i_subset_burst, i_subset_size} <= bs;
		@(posedge i_clk);
		{i_subset_req, i_split_nonmod, i_early_wr_err} <= 3'h0;
		repeat (2) @(posedge i_clk);
		rdc(8'h80, {29'h0, e});
		wr(8'h80, 32'h7);
	endtask : nm
	task automatic ep(input logic [20:0] r, input logic [20:0] c);
		@(posedge i_clk);
		raise <= r;
		clear <= c;
		@(posedge i_clk);
		raise <= '0;
		clear <= '0;
		repeat (3) @(posedge i_clk);
	endtask : ep
	initial begin
		i_clk = 1'b0;
		forever #4 i_clk = ~i_clk;
	end
	// The sequence needs well under two thousand cycles; ten times that means a hang.
	initial begin
		repeat (20000) @(posedge i_clk);
		errors++;
		end_of_test();
	end
	initial begin
		{i_rst_n, i_wr, i_rd, i_addr, i_wdata} = '0;
		{i_rd_err, i_wr_err, i_timeout_err, i_access_err, i_timeout_is_wr} = '0;
		{i_split_nonmod, i_early_wr_err, i_subset_req, i_subset_burst, i_subset_size} = '0;
		{raise, clear} = '0;
		{i_rd_txn_secure, i_wr_txn_secure} = 2'h3;
		repeat (10) @(posedge i_clk);
		i_rst_n <= 1'b1;
		rdc(8'h04, 32'h1);
		rdc(8'h20, 32'h1);
		rdc(8'h88, 32'h0);
		wr(8'h3C, 32'hFFFF_FFFF);
		rdc(8'h3C, 32'h0);
		evt(5'h18);
		rdc(8'h00, 32'h17);
		rdc(8'h08, wr_a[31:0]);
		rdc(8'h0C, wr_a[63:32]);
		rdc(8'h10, {16'h0, wr_a[15:0]});
		rdc(8'h14, {21'h0, wr_a[26:16]});
		rdc(8'h04, 32'h3);
		rdc(8'h18, 32'h1);
		chk("own irq", 32'h1, {25'h0, o_own_irq});
		chk("irq", 32'h1, {25'h0, o_irq});
		clr(8'h00);
		rdc(8'h00, 32'h0, 32'h7);
		evt(5'h0C);
		rdc(8'h00, 32'h27);
		rdc(8'h08, rd_a[31:0]);
		rdc(8'h18, 32'h3);
		clr(8'h00);
		evt(5'h08);
		wr(8'h18, 32'h7);
		rdc(8'h18, 32'h0);
		evt(5'h10);
		rdc(8'h00, 32'h17);
		rdc(8'h08, wr_a[31:0]);
		clr(8'h00);
		evt(5'h10);
		rdc(8'h08, rd_a[31:0]);
		clr(8'h00);
		evt(5'h02);
		rdc(8'h00, 32'h33);
		rdc(8'h18, 32'h4);
		clr(8'h00);
		wr(8'h04, 32'h0);
		evt(5'h08);
		rdc(8'h18, 32'h0);
		wr(8'h04, 32'h1);
		wr(8'h20, 32'h0);
		evt(5'h04);
		rdc(8'h18, 32'h0);
		evt(5'h08);
		rdc(8'h00, 32'h13);
		clr(8'h00);
		wr(8'h20, 32'h1);
		wr(8'h1C, 32'h1);
		evt(5'h08);
		rdc(8'h18, 32'h1);
		chk("own irq", 32'h0, {25'h0, o_own_irq});
		wr(8'h1C, 32'h0);
		clr(8'h00);
		{i_rd_txn_secure, i_wr_txn_secure} <= 2'h0;
		evt(5'h04);
		rdc(8'h40, 32'h23);
		rdc(8'h18, 32'h0);
		chk("own irq", 32'h10, {25'h0, o_own_irq});
		clr(8'h40);
		wr(8'h88, 32'h1);
		nm(3'h4, 5'h12, 3'h2);
		nm(3'h4, 5'h0D, 3'h2);
		nm(3'h4, 5'h0C, 3'h0);
		nm(3'h2, 5'h00, 3'h1);
		nm(3'h1, 5'h00, 3'h4);
		wr(8'h88, 32'h0);
		nm(3'h4, 5'h12, 3'h0);
		ep(21'h00204, 21'h0);
		rdc(8'hC8, 32'h8202);
		chk("irq", 32'h4, {25'h0, o_irq});
		ep(21'h10000, 21'h0);
		rdc(8'hC8, 32'h8203);
		ep(21'h0, 21'h00200);
		rdc(8'hC8, 32'h8102);
		wr(8'h8C, 32'h4);
		rdc(8'hC8, 32'h8102);
		chk("irq", 32'h0, {25'h0, o_irq});
		wr(8'h8C, 32'h0);
		ep(21'h0, 21'h10004);
		rdc(8'hC8, 32'h0, 32'h8007);
		chk("irq", 32'h0, {25'h0, o_irq});
		// Seven secure captures and one non-secure capture were logged above.
		chk("ras pulses", 32'h0000_0107, {16'h0000, ras1_n, ras0_n});
		end_of_test();
	end
endmodule : ehi_error_log_irq_test
